// file: verilog/tmsa_pkg.sv
// Constants, types and decode helpers of the temperature monitor serial slave
package tmsa_pkg;

    // ------------------------------------------------------------------
    // Serial slave
    // ------------------------------------------------------------------
    localparam logic [6:0] SLAVE_ADDR    = 7'h4c;
    localparam logic [3:0] BYTE_BITS     = 4'h8;
    localparam logic [3:0] BIT_CNT_ZERO  = 4'h0;
    localparam logic [3:0] BIT_CNT_STEP  = 4'h1;

    // ------------------------------------------------------------------
    // Register pointers and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] PTR_HYST      = 8'h21;
    localparam logic [7:0] PTR_COUNT     = 8'h22;
    localparam logic [7:0] PTR_PART      = 8'hfd;
    localparam logic [7:0] PTR_MAKER     = 8'hfe;
    localparam logic [7:0] HYST_RESET    = 8'h0a;
    localparam logic [7:0] COUNT_RESET   = 8'h70;
    localparam logic [7:0] COUNT_WR_MASK = 8'h7e;
    localparam logic [7:0] UNMAPPED_DATA = 8'h00;

    // ------------------------------------------------------------------
    // Consecutive count fields
    // ------------------------------------------------------------------
    localparam int OT_CNT_MSB = 6;
    localparam int OT_CNT_LSB = 4;
    localparam int AL_CNT_MSB = 3;
    localparam int AL_CNT_LSB = 1;

    // ------------------------------------------------------------------
    // Slave sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_ADDR    = 3'b001,
        ST_ACK_OUT = 3'b010,
        ST_RX      = 3'b011,
        ST_TX      = 3'b100,
        ST_ACK_IN  = 3'b101
    } tmsa_state_t;

    // Consecutive out-of-limit conversions needed before an alarm
    function automatic logic [2:0] tmsa_need(input logic [2:0] code);
        case (code)
            3'h0:    tmsa_need = 3'h1;
            3'h1:    tmsa_need = 3'h2;
            3'h3:    tmsa_need = 3'h3;
            3'h7:    tmsa_need = 3'h4;
            default: tmsa_need = 3'h1;
        endcase
    endfunction

endpackage

// file: verilog/tmsa_sync2.sv
// Two-stage synchroniser for a single level
`timescale 1ns/10ps
module tmsa_sync2 #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic d,
    output logic      q
);

    logic meta_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= RST_VAL;
            q      <= RST_VAL;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule // tmsa_sync2

// file: verilog/tmsa_alarm_filter.sv
// Consecutive-conversion filter with hysteresis release for one alarm
`timescale 1ns/10ps
module tmsa_alarm_filter (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       meas_valid,
    input  wire logic [7:0] meas_temp,
    input  wire logic [7:0] limit,
    input  wire logic [2:0] count_code,
    input  wire logic       hyst_en,
    input  wire logic [7:0] hyst,
    output logic            out_flag,
    output logic            alarm
);

    logic [2:0] need;
    logic       over;
    logic       release_ok;
    logic [2:0] run_r;
    logic [2:0] run_nxt;
    logic       fire;

    assign need       = tmsa_pkg::tmsa_need(count_code);
    assign over       = meas_temp > limit;
    // Sum kept 9 bits wide so a hysteresis above the limit never releases
    assign release_ok = hyst_en ? (({1'b0, meas_temp} + {1'b0, hyst}) <= {1'b0, limit}) : ~over;
    assign run_nxt    = !over ? 3'h0 : (run_r >= need) ? need : run_r + 3'h1;
    assign fire       = over && (run_nxt >= need);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_r    <= 3'h0;
            out_flag <= 1'b0;
            alarm    <= 1'b0;
        end else if (meas_valid) begin
            run_r    <= run_nxt;
            out_flag <= over;
            if (fire) begin
                alarm <= 1'b1;
            end else if (release_ok) begin
                alarm <= 1'b0;
            end
        end
    end

endmodule // tmsa_alarm_filter

// file: verilog/tmsa_top.sv
// Serial slave port with hysteresis, consecutive-count and identity registers
`timescale 1ns/10ps
module tmsa_top #(
    parameter logic [7:0] MAKER_CODE = 8'h01, // Arbitrary value
    parameter logic [7:0] PART_CODE  = 8'h02  // Arbitrary value
) (
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    input  wire logic       link_clk,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_n,
    input  wire logic       meas_valid,
    input  wire logic [7:0] meas_temp,
    input  wire logic [7:0] high_limit,
    input  wire logic [7:0] overtemp_limit,
    input  wire logic       alert_pin_function_select,
    output logic            alert_or_second_overtemp_pin,
    output logic            overtemp_pin,
    output logic            high_limit_flag,
    output logic            overtemp_flag
);

    // ------------------------------------------------------------------
    // Link-side declarations
    // ------------------------------------------------------------------
    tmsa_pkg::tmsa_state_t state_r;
    tmsa_pkg::tmsa_state_t state_nxt;
    logic                  scl_s;
    logic                  sda_s;
    logic                  scl_d_r;
    logic                  sda_d_r;
    logic                  scl_rise;
    logic                  scl_fall;
    logic                  start_det;
    logic                  stop_det;
    logic [3:0]            bit_cnt_r;
    logic [3:0]            bit_cnt_nxt;
    logic [7:0]            shift_r;
    logic [7:0]            shift_nxt;
    logic [7:0]            tx_r;
    logic [7:0]            tx_nxt;
    logic                  rw_r;
    logic                  rw_nxt;
    logic                  ptr_phase_r;
    logic                  ptr_phase_nxt;
    logic [7:0]            pointer_r;
    logic [7:0]            pointer_nxt;
    logic                  drive_low_r;
    logic                  drive_low_nxt;
    logic                  wr_en;
    logic                  wr_hyst;
    logic                  wr_count;
    logic                  addr_match;
    logic [7:0]            rd_data;
    logic [7:0]            hyst_r;
    logic [7:0]            count_r;

    // ------------------------------------------------------------------
    // Crossing declarations
    // ------------------------------------------------------------------
    logic [15:0]           cfg_live;
    logic [15:0]           cfg_hold_r;
    logic                  req_tgl_r;
    logic                  ack_s;
    logic                  cfg_idle;
    logic                  cfg_dirty;
    logic                  req_s;
    logic                  ack_tgl_r;
    logic                  cfg_take;
    logic [7:0]            core_hyst_r;
    logic [7:0]            core_count_r;

    // ------------------------------------------------------------------
    // Bus pin sampling
    // ------------------------------------------------------------------
    tmsa_sync2 #(
        .RST_VAL (1'b1)
    ) u_scl_sync (
        .clk     (link_clk),
        .rst_n   (reset_n),
        .d       (scl_i),
        .q       (scl_s)
    );

    tmsa_sync2 #(
        .RST_VAL (1'b1)
    ) u_sda_sync (
        .clk     (link_clk),
        .rst_n   (reset_n),
        .d       (sda_i),
        .q       (sda_s)
    );

    always_ff @(posedge link_clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    assign scl_rise  = scl_s & ~scl_d_r;
    assign scl_fall  = ~scl_s & scl_d_r;
    assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;

    // ------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------
    assign addr_match = shift_r[7:1] == tmsa_pkg::SLAVE_ADDR;
    assign wr_hyst    = wr_en & (pointer_r == tmsa_pkg::PTR_HYST);
    assign wr_count   = wr_en & (pointer_r == tmsa_pkg::PTR_COUNT);
    assign rd_data    = (pointer_r == tmsa_pkg::PTR_HYST)  ? hyst_r     :
                        (pointer_r == tmsa_pkg::PTR_COUNT) ? count_r    :
                        (pointer_r == tmsa_pkg::PTR_PART)  ? PART_CODE  :
                        (pointer_r == tmsa_pkg::PTR_MAKER) ? MAKER_CODE :
                        tmsa_pkg::UNMAPPED_DATA;

    // ------------------------------------------------------------------
    // Slave sequencer
    // ------------------------------------------------------------------
    always_comb begin
        state_nxt     = state_r;
        bit_cnt_nxt   = bit_cnt_r;
        shift_nxt     = shift_r;
        tx_nxt        = tx_r;
        rw_nxt        = rw_r;
        ptr_phase_nxt = ptr_phase_r;
        pointer_nxt   = pointer_r;
        drive_low_nxt = drive_low_r;
        wr_en         = 1'b0;
        if (start_det) begin
            state_nxt     = tmsa_pkg::ST_ADDR;
            bit_cnt_nxt   = tmsa_pkg::BIT_CNT_ZERO;
            drive_low_nxt = 1'b0;
        end else if (stop_det) begin
            state_nxt     = tmsa_pkg::ST_IDLE;
            drive_low_nxt = 1'b0;
        end else begin
            case (state_r)
                tmsa_pkg::ST_ADDR, tmsa_pkg::ST_RX: begin
                    if (scl_rise && (bit_cnt_r != tmsa_pkg::BYTE_BITS)) begin
                        shift_nxt   = {shift_r[6:0], sda_s};
                        bit_cnt_nxt = bit_cnt_r + tmsa_pkg::BIT_CNT_STEP;
                    end else if (scl_fall && (bit_cnt_r == tmsa_pkg::BYTE_BITS)) begin
                        bit_cnt_nxt = tmsa_pkg::BIT_CNT_ZERO;
                        if (state_r == tmsa_pkg::ST_RX) begin
                            drive_low_nxt = 1'b1;
                            state_nxt     = tmsa_pkg::ST_ACK_OUT;
                            if (ptr_phase_r) begin
                                pointer_nxt   = shift_r;
                                ptr_phase_nxt = 1'b0;
                            end else begin
                                wr_en = 1'b1;
                            end
                        end else if (addr_match) begin
                            rw_nxt        = shift_r[0];
                            ptr_phase_nxt = ~shift_r[0];
                            drive_low_nxt = 1'b1;
                            state_nxt     = tmsa_pkg::ST_ACK_OUT;
                        end else begin
                            state_nxt = tmsa_pkg::ST_IDLE;
                        end
                    end
                end
                tmsa_pkg::ST_ACK_OUT: begin
                    if (scl_fall) begin
                        bit_cnt_nxt = tmsa_pkg::BIT_CNT_ZERO;
                        if (rw_r) begin
                            tx_nxt        = rd_data;
                            drive_low_nxt = ~rd_data[7];
                            state_nxt     = tmsa_pkg::ST_TX;
                        end else begin
                            drive_low_nxt = 1'b0;
                            state_nxt     = tmsa_pkg::ST_RX;
                        end
                    end
                end
                tmsa_pkg::ST_TX: begin
                    if (scl_rise) begin
                        bit_cnt_nxt = bit_cnt_r + tmsa_pkg::BIT_CNT_STEP;
                    end else if (scl_fall) begin
                        if (bit_cnt_r == tmsa_pkg::BYTE_BITS) begin
                            drive_low_nxt = 1'b0;
                            state_nxt     = tmsa_pkg::ST_ACK_IN;
                        end else begin
                            tx_nxt        = {tx_r[6:0], 1'b0};
                            drive_low_nxt = ~tx_r[6];
                        end
                    end
                end
                tmsa_pkg::ST_ACK_IN: begin
                    if (scl_rise) begin
                        shift_nxt = {shift_r[7:1], sda_s};
                    end else if (scl_fall) begin
                        bit_cnt_nxt = tmsa_pkg::BIT_CNT_ZERO;
                        if (!shift_r[0]) begin
                            tx_nxt        = rd_data;
                            drive_low_nxt = ~rd_data[7];
                            state_nxt     = tmsa_pkg::ST_TX;
                        end else begin
                            state_nxt = tmsa_pkg::ST_IDLE;
                        end
                    end
                end
                default: begin
                    drive_low_nxt = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge link_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r     <= tmsa_pkg::ST_IDLE;
            bit_cnt_r   <= tmsa_pkg::BIT_CNT_ZERO;
            shift_r     <= 8'h00;
            tx_r        <= 8'h00;
            rw_r        <= 1'b0;
            ptr_phase_r <= 1'b0;
            pointer_r   <= 8'h00;
            drive_low_r <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            bit_cnt_r   <= bit_cnt_nxt;
            shift_r     <= shift_nxt;
            tx_r        <= tx_nxt;
            rw_r        <= rw_nxt;
            ptr_phase_r <= ptr_phase_nxt;
            pointer_r   <= pointer_nxt;
            drive_low_r <= drive_low_nxt;
        end
    end

    // SDA is open drain; SCL is only ever sampled
    assign sda_o    = 1'b0;
    assign sda_oe_n = ~drive_low_r;

    // ------------------------------------------------------------------
    // Writable registers
    // ------------------------------------------------------------------
    always_ff @(posedge link_clk or negedge reset_n) begin
        if (!reset_n) begin
            hyst_r  <= tmsa_pkg::HYST_RESET;
            count_r <= tmsa_pkg::COUNT_RESET;
        end else begin
            if (wr_hyst) begin
                hyst_r <= shift_r;
            end
            if (wr_count) begin
                count_r <= shift_r & tmsa_pkg::COUNT_WR_MASK;
            end
        end
    end

    // ------------------------------------------------------------------
    // Settings handshake from link to core
    // ------------------------------------------------------------------
    assign cfg_live  = {hyst_r, count_r};
    assign cfg_idle  = req_tgl_r == ack_s;
    assign cfg_dirty = cfg_hold_r != cfg_live;

    tmsa_sync2 #(
        .RST_VAL (1'b0)
    ) u_ack_sync (
        .clk     (link_clk),
        .rst_n   (reset_n),
        .d       (ack_tgl_r),
        .q       (ack_s)
    );

    // Hold stays frozen until the core has acknowledged it
    always_ff @(posedge link_clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_hold_r <= {tmsa_pkg::HYST_RESET, tmsa_pkg::COUNT_RESET};
            req_tgl_r  <= 1'b0;
        end else if (cfg_idle && cfg_dirty) begin
            cfg_hold_r <= cfg_live;
            req_tgl_r  <= ~req_tgl_r;
        end
    end

    tmsa_sync2 #(
        .RST_VAL (1'b0)
    ) u_req_sync (
        .clk     (core_clk),
        .rst_n   (reset_n),
        .d       (req_tgl_r),
        .q       (req_s)
    );

    assign cfg_take = req_s != ack_tgl_r;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            core_hyst_r  <= tmsa_pkg::HYST_RESET;
            core_count_r <= tmsa_pkg::COUNT_RESET;
            ack_tgl_r    <= 1'b0;
        end else if (cfg_take) begin
            core_hyst_r  <= cfg_hold_r[15:8];
            core_count_r <= cfg_hold_r[7:0];
            ack_tgl_r    <= req_s;
        end
    end

    // ------------------------------------------------------------------
    // Alarm filters
    // ------------------------------------------------------------------
    tmsa_alarm_filter u_overtemp_filter (
        .clk        (core_clk),
        .rst_n      (reset_n),
        .meas_valid (meas_valid),
        .meas_temp  (meas_temp),
        .limit      (overtemp_limit),
        .count_code (core_count_r[tmsa_pkg::OT_CNT_MSB:tmsa_pkg::OT_CNT_LSB]),
        .hyst_en    (1'b1),
        .hyst       (core_hyst_r),
        .out_flag   (overtemp_flag),
        .alarm      (overtemp_pin)
    );

    tmsa_alarm_filter u_alert_filter (
        .clk        (core_clk),
        .rst_n      (reset_n),
        .meas_valid (meas_valid),
        .meas_temp  (meas_temp),
        .limit      (high_limit),
        .count_code (core_count_r[tmsa_pkg::AL_CNT_MSB:tmsa_pkg::AL_CNT_LSB]),
        .hyst_en    (alert_pin_function_select),
        .hyst       (core_hyst_r),
        .out_flag   (high_limit_flag),
        .alarm      (alert_or_second_overtemp_pin)
    );

endmodule // tmsa_top

// file: verification/tmsa_monitor.sv
// Assertions on the serial slave and alarm outputs
`timescale 1ns/10ps
module tmsa_monitor (
    input wire logic       core_clk,
    input wire logic       reset_n,
    input wire logic       link_clk,
    input wire logic       scl_i,
    input wire logic       sda_i,
    input wire logic       sda_o,
    input wire logic       sda_oe_n,
    input wire logic       meas_valid,
    input wire logic [7:0] meas_temp,
    input wire logic [7:0] high_limit,
    input wire logic [7:0] overtemp_limit,
    input wire logic       alert_pin_function_select,
    input wire logic       alert_or_second_overtemp_pin,
    input wire logic       overtemp_pin,
    input wire logic       high_limit_flag,
    input wire logic       overtemp_flag
);
    // ----------------------------------------------------------------
    // Alarm side
    // ----------------------------------------------------------------
    high_flag_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        meas_valid |=> high_limit_flag == ($past(meas_temp) > $past(high_limit))) else $error("high flag wrong");
    ot_flag_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        meas_valid |=> overtemp_flag == ($past(meas_temp) > $past(overtemp_limit))) else $error("ot flag wrong");
    flag_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        !meas_valid |=> $stable(high_limit_flag) && $stable(overtemp_flag)) else $error("flag moved");
    alarm_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        !meas_valid |=> $stable(overtemp_pin) && $stable(alert_or_second_overtemp_pin)) else $error("alarm moved");
    ot_rise_cause_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        $rose(overtemp_pin) |-> overtemp_flag && $past(meas_valid)) else $error("ot alarm without cause");
    al_rise_cause_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        $rose(alert_or_second_overtemp_pin) |-> high_limit_flag) else $error("alert without cause");
    ot_release_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        $fell(overtemp_pin) |-> !overtemp_flag && $past(meas_valid)) else $error("bad ot release");
    in_limit_quiet_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        meas_valid && meas_temp <= overtemp_limit && !overtemp_pin |=> !overtemp_pin) else $error("ot raised");
    // ----------------------------------------------------------------
    // Bus side and cover points
    // ----------------------------------------------------------------
    sda_scl_low_a: assert property (@(posedge link_clk) disable iff (!reset_n)
        $changed(sda_oe_n) |-> !scl_i) else $error("sda moved with scl high");
    open_drain_a: assert property (@(posedge link_clk) disable iff (!reset_n)
        !sda_oe_n |-> sda_o == 1'b0) else $error("sda driven high");
    ot_up_c: cover property (@(posedge core_clk) disable iff (!reset_n) $rose(overtemp_pin));
    ot_down_c: cover property (@(posedge core_clk) disable iff (!reset_n) $fell(overtemp_pin));
    ack_c: cover property (@(posedge link_clk) disable iff (!reset_n) $fell(sda_oe_n));
endmodule // tmsa_monitor

// file: verification/tmsa_bus_master.sv
// Behavioural two-wire bus master facing the slave port
`timescale 1ns/10ps
module tmsa_bus_master #(
    parameter int HALF_NS = 600
) (
    output logic      scl,
    output logic      sda_drv,
    input  wire logic sda
);
    localparam int Q_NS = HALF_NS / 4;
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic start();
        #Q_NS sda_drv = 1'b1;
        #HALF_NS scl = 1'b1;
        #HALF_NS sda_drv = 1'b0;
        #HALF_NS scl = 1'b0;
    endtask
    task automatic stop();
        #Q_NS sda_drv = 1'b0;
        #HALF_NS scl = 1'b1;
        #HALF_NS sda_drv = 1'b1;
        #HALF_NS;
    endtask
    // Data moves only a quarter of a half period (HALF_NS / 4) after scl falls
    task automatic bit_io(input logic b, output logic r);
        #Q_NS sda_drv = b;
        #(HALF_NS - Q_NS) scl = 1'b1;
        #(HALF_NS / 2) r = sda;
        #(HALF_NS / 2) scl = 1'b0;
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], r);
        bit_io(1'b1, ack);
    endtask
    task automatic rbyte(input logic nack, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, b[i]);
        bit_io(nack, r);
    endtask
endmodule // tmsa_bus_master

// file: verification/tb_top.sv
// Top testbench of the temperature monitor serial slave
`timescale 1ns/10ps
module tb_top;
    localparam logic [7:0] MAKER = 8'h3c; // Arbitrary value
    localparam logic [7:0] PART  = 8'h5a; // Arbitrary value
    logic        core_clk, link_clk, reset_n, meas_valid, sel;
    logic [7:0]  meas_temp, high_limit, overtemp_limit, seen, cnt_reg, hyst_reg;
    logic [15:0] rnd;
    logic [2:0]  run [2];
    logic [1:0]  alm;
    logic [2:0]  codes [5] = '{3'h0, 3'h1, 3'h3, 3'h7, 3'h2};
    logic [7:0]  exp_q [$];
    int          mismatches, comparisons;
    wire         scl, sda_drv, sda_o, sda_oe_n, al_pin, ot_pin, hl_flag, ot_flag;
    wire         sda = sda_drv & (sda_oe_n | sda_o);
    event        got;
    tmsa_top #(.MAKER_CODE(MAKER), .PART_CODE(PART)) i_tmsa_top (
        .core_clk(core_clk), .reset_n(reset_n), .link_clk(link_clk), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_n(sda_oe_n), .meas_valid(meas_valid), .meas_temp(meas_temp), .high_limit(high_limit),
        .overtemp_limit(overtemp_limit), .alert_pin_function_select(sel), .alert_or_second_overtemp_pin(al_pin),
        .overtemp_pin(ot_pin), .high_limit_flag(hl_flag), .overtemp_flag(ot_flag));
    tmsa_bus_master i_tmsa_bus_master (.scl(scl), .sda_drv(sda_drv), .sda(sda));
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    initial begin
        link_clk = 1'b0;
        #13;
        forever #40 link_clk = ~link_clk;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] r);
        return {r[14:0], r[15] ^ r[13] ^ r[12] ^ r[10]};
    endfunction
    function automatic logic [2:0] need(input logic [2:0] c);
        return (c == 3'h1) ? 3'h2 : (c == 3'h3) ? 3'h3 : (c == 3'h7) ? 3'h4 : 3'h1;
    endfunction
    task automatic check(input logic [7:0] s, input logic [7:0] e);
        comparisons++;
        if (s !== e) begin
            mismatches++;
            $display("wrong value at %0t ns: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial forever begin
        @(got);
        check(seen, exp_q.pop_front());
    end
    task automatic sendb(input logic [7:0] b, input logic e);
        logic a;
        exp_q.push_back({7'h0, e});
        i_tmsa_bus_master.wbyte(b, a);
        seen = {7'h0, a};
        -> got;
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        i_tmsa_bus_master.start();
        sendb(8'h98, 1'b0);
        sendb(p, 1'b0);
        sendb(d, 1'b0);
        i_tmsa_bus_master.stop();
    endtask
    task automatic rd(input logic [7:0] p, input logic setp, input logic [7:0] e, input int n);
        logic [7:0] b;
        if (setp) begin
            i_tmsa_bus_master.start();
            sendb(8'h98, 1'b0);
            sendb(p, 1'b0);
        end
        i_tmsa_bus_master.start();
        sendb(8'h99, 1'b0);
        for (int i = 0; i < n; i++) begin
            exp_q.push_back(e);
            i_tmsa_bus_master.rbyte(i == n - 1, b);
            seen = b;
            -> got;
        end
        i_tmsa_bus_master.stop();
    endtask
    // Reference filter model, then one conversion pulse
    task automatic conv(input logic [7:0] t);
        logic [1:0] ov, rel;
        logic [8:0] s;
        s = {1'b0, t} + {1'b0, hyst_reg};
        ov = {t > overtemp_limit, t > high_limit};
        rel[0] = sel ? (s <= {1'b0, high_limit}) : !ov[0];
        rel[1] = s <= {1'b0, overtemp_limit};
        for (int c = 0; c < 2; c++) begin
            run[c] = ov[c] ? ((run[c] == 3'h7) ? 3'h7 : run[c] + 3'h1) : 3'h0;
            if (run[c] >= need(c ? cnt_reg[6:4] : cnt_reg[3:1]))
                alm[c] = 1'b1;
            else if (rel[c])
                alm[c] = 1'b0;
        end
        exp_q.push_back({4'h0, alm, ov});
        @(negedge core_clk);
        meas_valid = 1'b1;
        meas_temp = t;
        @(negedge core_clk);
        meas_valid = 1'b0;
        @(negedge core_clk);
        seen = {4'h0, ot_pin, al_pin, ot_flag, hl_flag};
        -> got;
    endtask
    initial begin
        repeat (100000) @(posedge core_clk);
        mismatches++;
        tally_and_finish();
    end
    initial begin
        reset_n = 1'b0;
        meas_valid = 1'b0;
        meas_temp = 8'h00;
        high_limit = 8'h32;
        overtemp_limit = 8'h3c;
        sel = 1'b0;
        mismatches = 0;
        comparisons = 0;
        rnd = 16'h50ac;
        run = '{3'h0, 3'h0};
        alm = 2'b00;
        repeat (20) @(negedge core_clk);
        reset_n = 1'b1;
        repeat (8) @(negedge core_clk);
        rd(8'h21, 1'b1, 8'h0a, 1);
        rd(8'h22, 1'b1, 8'h70, 1);
        rd(8'hfd, 1'b1, PART, 1);
        rd(8'hfe, 1'b1, MAKER, 1);
        rd(8'h40, 1'b1, 8'h00, 1);
        wr(8'hfe, 8'ha5);
        rd(8'hfe, 1'b1, MAKER, 1);
        wr(8'h22, 8'hff);
        rd(8'h22, 1'b1, 8'h7e, 1);
        i_tmsa_bus_master.start();
        sendb(8'h9a, 1'b1);
        i_tmsa_bus_master.stop();
        rd(8'h00, 1'b0, 8'h7e, 2);
        wr(8'h21, 8'hff);
        rd(8'h21, 1'b0, 8'hff, 1);
        rnd = lfsr(rnd);
        wr(8'h21, rnd[7:0]);
        rd(8'h21, 1'b0, rnd[7:0], 1);
        i_tmsa_bus_master.start();
        sendb(8'h98, 1'b0);
        sendb(8'h21, 1'b0);
        sendb(8'h33, 1'b0);
        sendb(8'h05, 1'b0);
        i_tmsa_bus_master.stop();
        rd(8'h21, 1'b0, 8'h05, 1);
        hyst_reg = 8'h05;
        foreach (codes[k]) begin
            cnt_reg = {1'b0, codes[k], codes[k], 1'b0};
            wr(8'h22, cnt_reg);
            repeat (20) @(negedge core_clk);
            sel = k[0];
            conv(8'h00);
            repeat (5) conv(8'h5a);
            repeat (12) begin
                rnd = lfsr(rnd);
                conv(8'h28 + {3'h0, rnd[4:0]});
            end
        end
        repeat (4) @(negedge core_clk);
        tally_and_finish();
    end
endmodule // tb_top
bind tmsa_top tmsa_monitor i_tmsa_monitor (
    .core_clk(core_clk), .reset_n(reset_n), .link_clk(link_clk), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .meas_valid(meas_valid), .meas_temp(meas_temp), .high_limit(high_limit),
    .overtemp_limit(overtemp_limit), .alert_pin_function_select(alert_pin_function_select),
    .alert_or_second_overtemp_pin(alert_or_second_overtemp_pin), .overtemp_pin(overtemp_pin),
    .high_limit_flag(high_limit_flag), .overtemp_flag(overtemp_flag));
